/* hw/alg_pkg.sv */
// alg_pkg: constants and carrier types for the alarm log / aux pin config register bank
// assumes a byte-wide command register port from the management bus engine
package alg_pkg;
    localparam logic [7:0] OFS_ALARM_LOG = 8'h05;
    localparam logic [7:0] OFS_WAIT_TIME = 8'h06;
    localparam logic [7:0] OFS_AUX_CFG = 8'h07;
    localparam logic [7:0] OFS_PIN_LOW = 8'h08;
    localparam logic [7:0] OFS_PIN_HIGH = 8'h09;
    localparam logic [7:0] RST_ALARM_LOG = 8'h00;
    localparam logic [7:0] RST_WAIT_TIME = 8'hFF;
    localparam logic [7:0] RST_AUX_CFG = 8'h00;
    localparam logic [7:0] RST_PIN_LOW = 8'h00;
    localparam logic [7:0] RST_PIN_HIGH = 8'hFF;
    localparam int BIT_POWER_HIGH = 7;
    localparam int BIT_POWER_LOW = 6;
    localparam int BIT_SENSE_HIGH = 5;
    localparam int BIT_SENSE_LOW = 4;
    localparam int BIT_SOURCE_HIGH = 3;
    localparam int BIT_SOURCE_LOW = 2;
    localparam int BIT_PIN_HIGH = 1;
    localparam int BIT_PIN_LOW = 0;
    localparam int BIT_AUX3_PD = 7;
    localparam int BIT_AUX2_PD = 6;
    localparam int BIT_AUX1_FN_HI = 5;
    localparam int BIT_AUX1_FN_LO = 4;
    localparam int BIT_AUX1_OUT = 3;
    localparam int BIT_CONV_ALERT = 2;
    localparam int BIT_STRESS_EN = 1;
    localparam int BIT_METER_ALERT = 0;
    localparam logic [1:0] FN_POWER_GOOD = 2'h0;
    localparam logic [1:0] FN_POWER_BAD = 2'h2;
    localparam logic [1:0] FN_OUTPUT = 2'h1;
    localparam logic [1:0] FN_INPUT = 2'h3;
    localparam logic [7:0] WAIT_DISABLED = 8'h00;
    localparam int CLK_HZ = 20000000;
    localparam int MS_CYCLES = CLK_HZ / 1000;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } alg_req_t;

    // one converter result with its channel
    typedef enum logic [1:0] {
        CH_POWER,
        CH_SENSE,
        CH_SOURCE,
        CH_PIN
    } alg_chan_t;

    typedef struct packed {
        logic valid;
        alg_chan_t chan;
        logic [7:0] value;
    } alg_result_t;

    // thresholds for the channels whose registers live elsewhere
    typedef struct packed {
        logic [7:0] power_low;
        logic [7:0] power_high;
        logic [7:0] sense_low;
        logic [7:0] sense_high;
        logic [7:0] source_low;
        logic [7:0] source_high;
    } alg_thresh_t;
endpackage

/* hw/alg_regs.sv */
// alg_regs: alarm log, transistor-bad wait time, aux pin config and pin voltage thresholds
// assumes converter results, thresholds, alert enables and status come from same-clock logic;
// aux_pin_one input arrives from a pin and is synchronised here
`timescale 1ns/1ps
// Overview of operation
// - power result above max sets log bit 7, below min sets bit 6
// - sense result above max sets log bit 5, below min sets bit 4
// - source result above max sets log bit 3, below min sets bit 2
// - pin result above max sets bit 1, below min sets bit 0; reset zero
// - 8-bit wait time in ms, default 255; zero disables transistor-bad detection
// - bit 7 pulls aux pin three low, bit 6 aux pin two; else high-Z
// - bits 5:4 pick aux pin one: good, output bit 3, bad, or input
// - conversion-done alert enable raises an alert on every finished measurement
// - stress enable pulls aux pin two low while the pass transistor is stressed
// - meter overflow alert enable raises alert on accumulator or time counter overflow
// - pin low threshold, default 0x00; values below it set the low alarm
// - pin high threshold, default 0xFF; values above it set the high alarm
// - enabled limit alerts fire at or above max, or at or below min
module alg_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire alg_pkg::alg_req_t req,
    output logic [7:0] rdata,
    input wire alg_pkg::alg_result_t result,
    input wire alg_pkg::alg_thresh_t thresh,
    input wire logic [7:0] limit_alert_en,
    input wire logic power_good,
    input wire logic power_bad,
    input wire logic stress,
    input wire logic meter_overflow,
    input wire logic fet_bad_cond,
    input wire logic aux_pin_one_i,
    output logic aux_pin_one_oe,
    output logic aux_pin_one_o,
    output logic aux_pin_two_oe,
    output logic aux_pin_two_o,
    output logic aux_pin_three_oe,
    output logic aux_pin_three_o,
    output logic alert_pulse,
    output logic fet_bad_fault,
    output logic aux_pin_one_level
);
    import alg_pkg::*;

    logic [7:0] alarm_log, next_alarm_log;
    logic [7:0] fet_bad_wait_time, next_fet_bad_wait_time;
    logic [7:0] aux_pin_config, next_aux_pin_config;
    logic [7:0] pin_voltage_low_threshold, next_pin_voltage_low_threshold;
    logic [7:0] pin_voltage_high_threshold, next_pin_voltage_high_threshold;
    logic [7:0] next_rdata;
    logic next_one_oe, next_two_oe, next_three_oe, next_alert;
    logic [14:0] ms_count, next_ms_count;
    logic [7:0] wait_ms, next_wait_ms;
    logic next_fet_bad_fault;
    logic pin1_meta, pin1_sync;
    logic [7:0] low_th, high_th;
    logic [1:0] idx;
    logic above, below, at_hi, at_lo;
    logic [7:0] set_bits;

    // threshold pick for the current result
    always_comb begin
        low_th = pin_voltage_low_threshold;
        high_th = pin_voltage_high_threshold;
        idx = 2'h0;
        case (result.chan)
            CH_POWER: begin
                low_th = thresh.power_low;
                high_th = thresh.power_high;
                idx = 2'h3;
            end
            CH_SENSE: begin
                low_th = thresh.sense_low;
                high_th = thresh.sense_high;
                idx = 2'h2;
            end
            CH_SOURCE: begin
                low_th = thresh.source_low;
                high_th = thresh.source_high;
                idx = 2'h1;
            end
            default: begin
                idx = 2'h0;
            end
        endcase
        above = result.valid && (result.value > high_th);
        below = result.valid && (result.value < low_th);
        at_hi = result.valid && (result.value >= high_th);
        at_lo = result.valid && (result.value <= low_th);
        set_bits = 8'h00;
        set_bits[{idx, 1'b1}] = above;
        set_bits[{idx, 1'b0}] = below;
    end

    // register writes and the sticky log
    always_comb begin
        next_alarm_log = alarm_log;
        next_fet_bad_wait_time = fet_bad_wait_time;
        next_aux_pin_config = aux_pin_config;
        next_pin_voltage_low_threshold = pin_voltage_low_threshold;
        next_pin_voltage_high_threshold = pin_voltage_high_threshold;
        if (req.wr) begin
            case (req.addr)
                OFS_ALARM_LOG: next_alarm_log = alarm_log & req.wdata;
                OFS_WAIT_TIME: next_fet_bad_wait_time = req.wdata;
                OFS_AUX_CFG: next_aux_pin_config = req.wdata;
                OFS_PIN_LOW: next_pin_voltage_low_threshold = req.wdata;
                OFS_PIN_HIGH: next_pin_voltage_high_threshold = req.wdata;
                default: next_alarm_log = alarm_log;
            endcase
        end
        next_alarm_log = next_alarm_log | set_bits;
        case (req.addr)
            OFS_ALARM_LOG: next_rdata = alarm_log;
            OFS_WAIT_TIME: next_rdata = fet_bad_wait_time;
            OFS_AUX_CFG: next_rdata = aux_pin_config;
            OFS_PIN_LOW: next_rdata = pin_voltage_low_threshold;
            OFS_PIN_HIGH: next_rdata = pin_voltage_high_threshold;
            default: next_rdata = 8'h00;
        endcase
        if (!req.rd) begin
            next_rdata = rdata;
        end
    end

    // pin drive and alert
    always_comb begin
        next_three_oe = aux_pin_config[BIT_AUX3_PD];
        next_two_oe = aux_pin_config[BIT_AUX2_PD] || (aux_pin_config[BIT_STRESS_EN] && stress);
        case (aux_pin_config[BIT_AUX1_FN_HI:BIT_AUX1_FN_LO])
            FN_POWER_GOOD: next_one_oe = !power_good;
            FN_POWER_BAD: next_one_oe = !power_bad;
            FN_OUTPUT: next_one_oe = !aux_pin_config[BIT_AUX1_OUT];
            default: next_one_oe = 1'b0;
        endcase
        next_alert = (aux_pin_config[BIT_CONV_ALERT] && result.valid)
            || (aux_pin_config[BIT_METER_ALERT] && meter_overflow)
            || (limit_alert_en[{idx, 1'b1}] && at_hi)
            || (limit_alert_en[{idx, 1'b0}] && at_lo);
    end

    // transistor-bad wait timer in milliseconds
    always_comb begin
        next_ms_count = ms_count;
        next_wait_ms = wait_ms;
        next_fet_bad_fault = fet_bad_fault;
        if (!fet_bad_cond || fet_bad_wait_time == WAIT_DISABLED) begin
            next_ms_count = 15'h0000;
            next_wait_ms = 8'h00;
            next_fet_bad_fault = 1'b0;
        end else if (ms_count == 15'(MS_CYCLES - 1)) begin
            next_ms_count = 15'h0000;
            if (wait_ms >= fet_bad_wait_time - 8'h01) begin
                next_fet_bad_fault = 1'b1;
            end else begin
                next_wait_ms = wait_ms + 8'h01;
            end
        end else begin
            next_ms_count = ms_count + 15'h0001;
        end
    end

    // register bank and read data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarm_log <= RST_ALARM_LOG;
            fet_bad_wait_time <= RST_WAIT_TIME;
            aux_pin_config <= RST_AUX_CFG;
            pin_voltage_low_threshold <= RST_PIN_LOW;
            pin_voltage_high_threshold <= RST_PIN_HIGH;
            rdata <= 8'h00;
        end else begin
            alarm_log <= next_alarm_log;
            fet_bad_wait_time <= next_fet_bad_wait_time;
            aux_pin_config <= next_aux_pin_config;
            pin_voltage_low_threshold <= next_pin_voltage_low_threshold;
            pin_voltage_high_threshold <= next_pin_voltage_high_threshold;
            rdata <= next_rdata;
        end
    end

    // pin enables and alert pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aux_pin_one_oe <= 1'b0;
            aux_pin_two_oe <= 1'b0;
            aux_pin_three_oe <= 1'b0;
            alert_pulse <= 1'b0;
        end else begin
            aux_pin_one_oe <= next_one_oe;
            aux_pin_two_oe <= next_two_oe;
            aux_pin_three_oe <= next_three_oe;
            alert_pulse <= next_alert;
        end
    end

    // transistor-bad wait timer state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ms_count <= 15'h0000;
            wait_ms <= 8'h00;
            fet_bad_fault <= 1'b0;
        end else begin
            ms_count <= next_ms_count;
            wait_ms <= next_wait_ms;
            fet_bad_fault <= next_fet_bad_fault;
        end
    end

    // two-flop synchroniser for aux pin one, then the output register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin1_meta <= 1'b0;
            pin1_sync <= 1'b0;
            aux_pin_one_level <= 1'b0;
        end else begin
            pin1_meta <= aux_pin_one_i;
            pin1_sync <= pin1_meta;
            aux_pin_one_level <= pin1_sync;
        end
    end

    // open-drain pins only ever drive low
    always_ff @(posedge clk_sys) begin
        aux_pin_one_o <= 1'b0;
        aux_pin_two_o <= 1'b0;
        aux_pin_three_o <= 1'b0;
    end
endmodule

/* bench/alg_pins.sv */
// alg_pins: board side of the three aux pins, pull-ups plus a driver that can hold pin one low
// assumes an oe input high means the device pulls that pin low
`timescale 1ns/1ps
module alg_pins (
    input wire logic [2:0] oe,
    input wire logic ext_low,
    output logic [2:0] pin
);
    assign pin[0] = !(oe[0] || ext_low);
    assign pin[2:1] = ~oe[2:1];
endmodule

/* bench/alg_regs_chk.sv */
// alg_regs_chk: port-level assertions for the alarm log and aux pin register bank
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module alg_regs_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire alg_pkg::alg_req_t req,
    input wire alg_pkg::alg_result_t result,
    input wire alg_pkg::alg_thresh_t thresh,
    input wire logic [7:0] limit_alert_en,
    input wire logic meter_overflow,
    input wire logic fet_bad_cond,
    input wire logic aux_pin_three_oe,
    input wire logic aux_pin_three_o,
    input wire logic alert_pulse,
    input wire logic fet_bad_fault
);
    import alg_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_limit(logic hit, logic en);
        result.valid && hit && en |=> alert_pulse;
    endproperty
    a_power_high: assert property (p_limit(result.chan == CH_POWER && result.value >= thresh.power_high,
        limit_alert_en[BIT_POWER_HIGH])) else $error("power high alert missing");
    a_power_low: assert property (p_limit(result.chan == CH_POWER && result.value <= thresh.power_low,
        limit_alert_en[BIT_POWER_LOW])) else $error("power low alert missing");
    a_sense_high: assert property (p_limit(result.chan == CH_SENSE && result.value >= thresh.sense_high,
        limit_alert_en[BIT_SENSE_HIGH])) else $error("sense high alert missing");
    a_source_low: assert property (p_limit(result.chan == CH_SOURCE && result.value <= thresh.source_low,
        limit_alert_en[BIT_SOURCE_LOW])) else $error("source low alert missing");
    a_alert_no_cause: assert property (!result.valid && !meter_overflow |=> !alert_pulse)
        else $error("alert without a cause");
    a_fault_drops: assert property (!fet_bad_cond |=> !fet_bad_fault)
        else $error("fault stays without condition");
    a_cfg_three: assert property (req.wr && req.addr == OFS_AUX_CFG ##1 !(req.wr && req.addr == OFS_AUX_CFG)
        |=> aux_pin_three_oe == $past(req.wdata[BIT_AUX3_PD], 2)) else $error("pin three enable wrong");
    a_three_drive: assert property (aux_pin_three_o == 1'b0) else $error("pin three driven high");
    c_alert: cover property (alert_pulse);
    c_fault: cover property (fet_bad_fault);
    c_three: cover property (aux_pin_three_oe);
endmodule
bind alg_regs alg_regs_chk chk_u (.clk_sys(clk_sys), .rst(rst), .req(req), .result(result), .thresh(thresh),
    .limit_alert_en(limit_alert_en), .meter_overflow(meter_overflow), .fet_bad_cond(fet_bad_cond),
    .aux_pin_three_oe(aux_pin_three_oe), .aux_pin_three_o(aux_pin_three_o), .alert_pulse(alert_pulse),
    .fet_bad_fault(fet_bad_fault));

/* bench/alg_regs_tb_top.sv */
// alg_regs_tb_top: register, alarm, pin, alert and fault tests for the register bank
// assumes inputs change at the falling edge and one millisecond is MS_CYCLES clocks
`timescale 1ns/1ps
module alg_regs_tb_top;
    import alg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    alg_req_t req = '0;
    alg_result_t result = '0;
    alg_thresh_t thresh = {3{8'h10, 8'hF0}};
    logic [7:0] limit_alert_en = 8'hFF;
    logic [7:0] rdata;
    logic [2:0] oe, o, pin;
    logic pg = 1'b1, pb = 1'b0, stress = 1'b0, meter = 1'b0, cond = 1'b0, ext_low = 1'b0, alert, fault, level;
    int err_count = 0;
    int total_checks = 0;
    alg_regs dut_u (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .result(result), .thresh(thresh),
        .limit_alert_en(limit_alert_en), .power_good(pg), .power_bad(pb), .stress(stress), .meter_overflow(meter),
        .fet_bad_cond(cond), .aux_pin_one_i(pin[0]), .aux_pin_one_oe(oe[0]), .aux_pin_one_o(o[0]),
        .aux_pin_two_oe(oe[1]), .aux_pin_two_o(o[1]), .aux_pin_three_oe(oe[2]), .aux_pin_three_o(o[2]),
        .alert_pulse(alert), .fet_bad_fault(fault), .aux_pin_one_level(level));
    alg_pins pins_u (.oe(oe), .ext_low(ext_low), .pin(pin));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        step(1);
        req = '0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{1'b0, 1'b1, a, 8'h00};
        step(1);
        req = '0;
        chk(rdata, exp);
        step(1);
    endtask
    task automatic send(input alg_chan_t ch, input logic [7:0] v);
        result = '{1'b1, ch, v};
        step(1);
        result = '0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        err_count++;
        close_out();
    end
    initial begin
        step(20);
        rst = 1'b0;
        rd(OFS_ALARM_LOG, RST_ALARM_LOG);
        rd(OFS_WAIT_TIME, RST_WAIT_TIME);
        rd(OFS_AUX_CFG, RST_AUX_CFG);
        rd(OFS_PIN_LOW, RST_PIN_LOW);
        rd(OFS_PIN_HIGH, RST_PIN_HIGH);
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'h00);
        $display("reset test done");
        wr(OFS_PIN_LOW, 8'h40);
        wr(OFS_PIN_HIGH, 8'hC0);
        rd(OFS_PIN_LOW, 8'h40);
        rd(OFS_PIN_HIGH, 8'hC0);
        send(CH_PIN, 8'h40);
        chk_bit(alert, 1'b1);
        send(CH_PIN, 8'hC0);
        chk_bit(alert, 1'b1);
        rd(OFS_ALARM_LOG, 8'h00);
        send(CH_PIN, 8'h3F);
        send(CH_PIN, 8'hC1);
        rd(OFS_ALARM_LOG, 8'h03);
        wr(OFS_ALARM_LOG, 8'hFE);
        rd(OFS_ALARM_LOG, 8'h02);
        for (int i = 0; i < 3; i++) begin
            send(alg_chan_t'(i), 8'hFF);
            chk_bit(alert, 1'b1);
            send(alg_chan_t'(i), 8'h00);
        end
        rd(OFS_ALARM_LOG, 8'hFE);
        limit_alert_en = 8'h00;
        send(CH_POWER, 8'hFF);
        chk_bit(alert, 1'b0);
        req = '{1'b1, 1'b0, OFS_ALARM_LOG, 8'h00};
        send(CH_PIN, 8'h00);
        req = '0;
        step(1);
        rd(OFS_ALARM_LOG, 8'h01);
        limit_alert_en = 8'hFF;
        wr(OFS_ALARM_LOG, 8'h00);
        rd(OFS_ALARM_LOG, 8'h00);
        $display("alarm test done");
        for (int i = 0; i < 7; i++) begin
            pg = 1'(7'b1111101 >> i);
            pb = 1'(7'b0000100 >> i);
            wr(OFS_AUX_CFG, 8'(56'h30_18_10_20_20_00_00 >> (8 * i)));
            chk_bit(pin[0], 1'(7'b1100101 >> i));
        end
        ext_low = 1'b1;
        step(4);
        chk_bit(level, 1'b0);
        ext_low = 1'b0;
        wr(OFS_AUX_CFG, 8'hC0);
        chk({6'h00, pin[2:1]}, 8'h00);
        chk({5'h00, o}, 8'h00);
        wr(OFS_AUX_CFG, 8'h02);
        chk({6'h00, pin[2:1]}, 8'h03);
        chk_bit(level, 1'b1);
        stress = 1'b1;
        step(2);
        chk_bit(pin[1], 1'b0);
        wr(OFS_AUX_CFG, 8'h00);
        chk_bit(pin[1], 1'b1);
        stress = 1'b0;
        $display("pin test done");
        for (int i = 0; i < 2; i++) begin
            wr(OFS_AUX_CFG, i[0] ? 8'h05 : 8'h00);
            send(CH_PIN, 8'h80);
            chk_bit(alert, i[0]);
            meter = 1'b1;
            step(1);
            meter = 1'b0;
            chk_bit(alert, i[0]);
        end
        $display("alert test done");
        wr(OFS_WAIT_TIME, 8'h01);
        cond = 1'b1;
        step(MS_CYCLES - 10);
        chk_bit(fault, 1'b0);
        step(20);
        chk_bit(fault, 1'b1);
        cond = 1'b0;
        wr(OFS_WAIT_TIME, WAIT_DISABLED);
        rd(OFS_WAIT_TIME, 8'h00);
        cond = 1'b1;
        step(MS_CYCLES + 2000);
        chk_bit(fault, 1'b0);
        cond = 1'b0;
        $display("fault test done");
        close_out();
    end
endmodule
